// *** rtl/lpcb_map.svh ***
// register offsets, field positions, reset values and counts of the led bank
// assumes byte-wide registers addressed by an 8-bit pointer
`ifndef LPCB_MAP_SVH
`define LPCB_MAP_SVH

`define LPCB_NCH 18
`define LPCB_GROUP_BITS 6
`define LPCB_OFS_SHUTDOWN 8'h00
`define LPCB_OFS_DUTY_FIRST 8'h01
`define LPCB_OFS_DUTY_LAST 8'h12
`define LPCB_OFS_EN_GROUP1 8'h13
`define LPCB_OFS_EN_GROUP2 8'h14
`define LPCB_OFS_EN_GROUP3 8'h15
`define LPCB_OFS_COMMIT 8'h16
`define LPCB_OFS_SOFT_RESET 8'h17
`define LPCB_SOFT_RUN_POS 0
`define LPCB_RST_SOFT_RUN 1'h0
`define LPCB_RST_DUTY 8'h00
`define LPCB_RST_ENABLE 1'h0
`define LPCB_RST_PTR 8'h00
`define LPCB_PWM_STEPS 256
`define LPCB_PWM_PRESCALE 1

`endif

// *** rtl/lpcb_pkg.sv ***
// types shared by the led bank modules
// assumes nothing beyond the map header
package lpcb_pkg;
  typedef logic [7:0] lpcb_byte_t;
  typedef enum logic [2:0] {
    LPCB_SEL_SHUTDOWN = 3'b000,
    LPCB_SEL_DUTY = 3'b001,
    LPCB_SEL_ENABLE = 3'b010,
    LPCB_SEL_COMMIT = 3'b011,
    LPCB_SEL_RESET = 3'b100,
    LPCB_SEL_NONE = 3'b101
  } lpcb_sel_t;
endpackage

// *** rtl/lpcb_pwm_if.sv ***
// carrier between the register bank and the pwm generator
// assumes both ends share the one clock
`timescale 1ns/1ps
`include "lpcb_map.svh"
interface lpcb_pwm_if;
  import lpcb_pkg::*;
  lpcb_byte_t duty [`LPCB_NCH];
  logic [`LPCB_NCH-1:0] enable;
  logic gate;
  logic [`LPCB_NCH-1:0] out;
  modport ctrl (output duty, output enable, output gate, input out);
  modport gen (input duty, input enable, input gate, output out);
endinterface

// *** rtl/lpcb_sync.sv ***
// two-flop synchroniser, also used to release the reset
// assumes rst_n may be asynchronous; q takes RST_VAL while it is low
`timescale 1ns/1ps
module lpcb_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // level in and out
  input wire logic d,
  output logic q
);
  logic meta_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // lpcb_sync

// *** rtl/lpcb_pwm.sv ***
// 256-step pwm generator for all channels
// assumes duty, enable and gate are stable values from the same clock
`timescale 1ns/1ps
`include "lpcb_map.svh"
module lpcb_pwm
  import lpcb_pkg::*;
#(
  parameter int PRESCALE = `LPCB_PWM_PRESCALE
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // channel settings and outputs
  lpcb_pwm_if.gen pwm
);
  logic [15:0] presc_reg;
  logic [7:0] count_reg;
  logic [`LPCB_NCH-1:0] out_reg;
  wire tick = (presc_reg == 16'(PRESCALE - 1));

  // slower pwm rate as an enable pulse, no second clock
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      presc_reg <= 16'h0000;
    else if (tick)
      presc_reg <= 16'h0000;
    else
      presc_reg <= presc_reg + 16'h0001;
  end

  // R19 free-running period
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count_reg <= 8'h00;
    else if (tick)
      count_reg <= count_reg + 8'h01;
  end

  genvar ch;
  generate
    for (ch = 0; ch < `LPCB_NCH; ch++)
    begin : g_ch
      wire phase_on = (count_reg < pwm.duty[ch]);
      // R20 conduct only when every condition holds
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          out_reg[ch] <= 1'b0;
        else
          out_reg[ch] <= pwm.gate & pwm.enable[ch] & phase_on;
      end
    end
  endgenerate

  assign pwm.out = out_reg;
endmodule // lpcb_pwm

// *** rtl/lpcb_top.sv ***
// register bank and output control of the 18-channel led driver
// assumes an upstream serial slave hands over address and data bytes
// as one-cycle strobes on MCLK; the halt pin is asynchronous
//
// Summary of operation
// R01 - register 14h bits 5:0 enable outputs 7 to 12, reset zero.
// R02 - register 15h bits 5:0 enable outputs 13 to 18, reset zero.
// R03 - an enable bit of zero turns its output off, one on.
// R04 - duty and enable writes land in holding registers only.
// R05 - any write to 16h copies held 01h to 15h to active set.
// R06 - any write to 17h returns every register to default.
// R07 - at power-up all registers are default and outputs dark.
// R08 - eighteen duty registers at 01h to 12h, 256 steps each.
// R09 - the duty value selects the pwm step directly.
// R10 - both shutdown modes keep all register contents.
// R11 - shutdown bit zero switches every output off.
// R12 - hardware shutdown lasts while the halt pin is low.
// R13 - host may write gamma-corrected duty from a 32-entry curve.
// R14 - host uses 64 entries for two-second, 32 for one-second breath.
// R15 - host may flash by toggling shutdown, registers survive.
// R16 - shutdown bit one runs, zero shuts down, default zero.
// R17 - register 13h bits 5:0 enable outputs 1 to 6.
// R18 - pointer advances by one after each data byte.
// R19 - each output on for duty counts of a 256-count period.
// R20 - output needs enable, shutdown bit, pin high and pwm phase.
`timescale 1ns/1ps
`include "lpcb_map.svh"
module lpcb_top
  import lpcb_pkg::*;
#(
  parameter int NCH = `LPCB_NCH,
  parameter int PWM_PRESCALE = `LPCB_PWM_PRESCALE
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_B,
  // register bytes from the serial slave
  input wire logic ADDR_BYTE_VALID,
  input wire logic [7:0] ADDR_BYTE,
  input wire logic DATA_BYTE_VALID,
  input wire logic [7:0] DATA_BYTE,
  // hardware shutdown pin
  input wire logic HW_HALT_N_PIN,
  // led outputs and state
  output logic [NCH-1:0] CHANNEL_OUTPUT,
  output logic SOFT_RUN,
  output logic HALTED
);
  logic rst_n;
  logic halt_n_sync;
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  logic soft_run_reg;
  logic soft_run_next;
  logic halted_reg;
  lpcb_byte_t hold_duty_reg [NCH];
  lpcb_byte_t act_duty_reg [NCH];
  logic [NCH-1:0] hold_en_reg;
  logic [NCH-1:0] act_en_reg;

  lpcb_pwm_if pwm_bus ();

  // reset release, assert stays asynchronous
  lpcb_sync #(
    .RST_VAL(1'b0)
  ) u_rst_sync (
    .clk(MCLK),
    .rst_n(RST_B),
    .d(1'b1),
    .q(rst_n)
  );

  // pin held low until proven high, so outputs stay dark at start
  lpcb_sync #(
    .RST_VAL(1'b0)
  ) u_halt_sync (
    .clk(MCLK),
    .rst_n(rst_n),
    .d(HW_HALT_N_PIN),
    .q(halt_n_sync)
  );

  // register decode on the current pointer
  wire is_shutdown = (ptr_reg == `LPCB_OFS_SHUTDOWN);
  wire is_duty = (ptr_reg >= `LPCB_OFS_DUTY_FIRST)
    && (ptr_reg <= `LPCB_OFS_DUTY_LAST);
  wire is_enable = (ptr_reg >= `LPCB_OFS_EN_GROUP1)
    && (ptr_reg <= `LPCB_OFS_EN_GROUP3);
  wire is_commit = (ptr_reg == `LPCB_OFS_COMMIT);
  wire is_reset = (ptr_reg == `LPCB_OFS_SOFT_RESET);

  lpcb_sel_t sel;
  assign sel = is_shutdown ? LPCB_SEL_SHUTDOWN :
    is_duty ? LPCB_SEL_DUTY :
    is_enable ? LPCB_SEL_ENABLE :
    is_commit ? LPCB_SEL_COMMIT :
    is_reset ? LPCB_SEL_RESET : LPCB_SEL_NONE;

  // R05 any byte value triggers, the data is ignored
  wire commit_wr = DATA_BYTE_VALID && (sel == LPCB_SEL_COMMIT);
  // R06 any byte value triggers a full return to defaults
  wire soft_rst_wr = DATA_BYTE_VALID && (sel == LPCB_SEL_RESET);
  wire shutdown_wr = DATA_BYTE_VALID && (sel == LPCB_SEL_SHUTDOWN);
  wire duty_wr = DATA_BYTE_VALID && (sel == LPCB_SEL_DUTY);
  wire enable_wr = DATA_BYTE_VALID && (sel == LPCB_SEL_ENABLE);

  // R18 new address byte loads, each data byte steps by one
  assign ptr_next = ADDR_BYTE_VALID ? ADDR_BYTE :
    DATA_BYTE_VALID ? ptr_reg + 8'h01 : ptr_reg;

  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
      ptr_reg <= `LPCB_RST_PTR;
    else
      ptr_reg <= ptr_next;
  end

  // R16 shutdown bit takes effect at once, it is not staged
  always_comb
  begin
    soft_run_next = soft_run_reg;
    unique case (1'b1)
      soft_rst_wr: soft_run_next = `LPCB_RST_SOFT_RUN;
      shutdown_wr: soft_run_next = DATA_BYTE[`LPCB_SOFT_RUN_POS];
      default: soft_run_next = soft_run_reg;
    endcase
  end

  // R07 power-up default keeps every output dark
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
      soft_run_reg <= `LPCB_RST_SOFT_RUN;
    else
      soft_run_reg <= soft_run_next;
  end

  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
      halted_reg <= 1'b1;
    else
      halted_reg <= ~(soft_run_next & halt_n_sync);
  end

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++)
    begin : g_ch
      localparam logic [7:0] DUTY_OFS = 8'(`LPCB_OFS_DUTY_FIRST + ch);
      localparam logic [7:0] EN_OFS =
        8'(`LPCB_OFS_EN_GROUP1 + ch / `LPCB_GROUP_BITS);
      localparam int EN_BIT = ch % `LPCB_GROUP_BITS;
      // R08 one duty holding register per channel, consecutive
      wire duty_hit = duty_wr && (ptr_reg == DUTY_OFS);
      // R17 group one covers channels 1 to 6
      // R01 group two covers channels 7 to 12
      // R02 group three covers channels 13 to 18
      wire en_hit = enable_wr && (ptr_reg == EN_OFS);

      // R04 host writes reach only the holding copy
      always_ff @(posedge MCLK or negedge rst_n)
      begin
        if (!rst_n)
        begin
          hold_duty_reg[ch] <= `LPCB_RST_DUTY;
          hold_en_reg[ch] <= `LPCB_RST_ENABLE;
        end
        else if (soft_rst_wr)
        begin
          hold_duty_reg[ch] <= `LPCB_RST_DUTY;
          hold_en_reg[ch] <= `LPCB_RST_ENABLE;
        end
        else
        begin
          if (duty_hit)
            hold_duty_reg[ch] <= DATA_BYTE;
          if (en_hit)
            hold_en_reg[ch] <= DATA_BYTE[EN_BIT];
        end
      end

      // R05 commit copies the whole held set in one edge
      // R10 shutdown never touches either copy
      always_ff @(posedge MCLK or negedge rst_n)
      begin
        if (!rst_n)
        begin
          act_duty_reg[ch] <= `LPCB_RST_DUTY;
          act_en_reg[ch] <= `LPCB_RST_ENABLE;
        end
        else if (soft_rst_wr)
        begin
          act_duty_reg[ch] <= `LPCB_RST_DUTY;
          act_en_reg[ch] <= `LPCB_RST_ENABLE;
        end
        else if (commit_wr)
        begin
          act_duty_reg[ch] <= hold_duty_reg[ch];
          act_en_reg[ch] <= hold_en_reg[ch];
        end
      end

      // R09 active duty value is the step count itself
      assign pwm_bus.duty[ch] = act_duty_reg[ch];
    end
  endgenerate

  // R03 enable bit zero blocks its output, one lets pwm through
  assign pwm_bus.enable = act_en_reg;
  // R11 shutdown bit low gates every output off
  // R12 halt pin low gates every output off while it stays low
  assign pwm_bus.gate = soft_run_reg & halt_n_sync;

  lpcb_pwm #(
    .PRESCALE(PWM_PRESCALE)
  ) u_pwm (
    .clk(MCLK),
    .rst_n(rst_n),
    .pwm(pwm_bus.gen)
  );

  // outputs come straight from the pwm flops
  assign CHANNEL_OUTPUT = pwm_bus.out;
  assign SOFT_RUN = soft_run_reg;
  assign HALTED = halted_reg;
endmodule // lpcb_top

// *** dv/lpcb_chk.sv ***
// assertions on the led bank top ports
// assumes one clock and a bind to lpcb_top
`timescale 1ns/1ps
module lpcb_chk #(
  parameter int NCH = 18
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_B,
  // byte strobes
  input wire logic ADDR_BYTE_VALID,
  input wire logic [7:0] ADDR_BYTE,
  input wire logic DATA_BYTE_VALID,
  input wire logic [7:0] DATA_BYTE,
  // pin and outputs
  input wire logic HW_HALT_N_PIN,
  input wire logic [NCH-1:0] CHANNEL_OUTPUT,
  input wire logic SOFT_RUN,
  input wire logic HALTED
);
  logic [7:0] ptr_reg;
  wire logic lsb = DATA_BYTE[0];
  wire logic run_w = DATA_BYTE_VALID && ptr_reg == 8'h00;
  wire logic rst_w = DATA_BYTE_VALID && ptr_reg == 8'h17;
  // address wins over data for the pointer
  always_ff @(posedge MCLK or negedge RST_B)
    if (!RST_B)
      ptr_reg <= 8'h00;
    else if (ADDR_BYTE_VALID || DATA_BYTE_VALID)
      ptr_reg <= ADDR_BYTE_VALID ? ADDR_BYTE : ptr_reg + 8'h01;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  AST_RUN_WRITE: assert property (run_w |=> SOFT_RUN == $past(lsb))
    else $error("run bit");
  AST_SOFT_RESET: assert property (rst_w |=> !SOFT_RUN)
    else $error("soft reset");
  AST_RUN_KEPT: assert property (!run_w && !rst_w |=> $stable(SOFT_RUN))
    else $error("run bit moved");
  AST_PIN_HALT: assert property (!HW_HALT_N_PIN [*4] |-> HALTED)
    else $error("pin halt");
  AST_SOFT_HALT: assert property (!SOFT_RUN [*2] |-> HALTED)
    else $error("soft halt");
  AST_RUNNING: assert property ((SOFT_RUN && HW_HALT_N_PIN) [*5] |-> !HALTED)
    else $error("not running");
  AST_DARK: assert property (HALTED [*3] |-> CHANNEL_OUTPUT == '0)
    else $error("lit while halted");
  AST_RESET_DARK: assert property (rst_w |-> ##3 CHANNEL_OUTPUT == '0)
    else $error("lit after reset");
endmodule // lpcb_chk

// *** dv/lpcb_host.sv ***
// host model issuing register bytes to the led bank
// assumes strobes are taken on the rising clock edge
`timescale 1ns/1ps
module lpcb_host (
  // clock
  input wire logic clk,
  // byte strobes towards the bank
  output logic av,
  output logic [7:0] a,
  output logic dv,
  output logic [7:0] d
);
  initial
  begin
    av = 1'b0;
    dv = 1'b0;
    a = 8'h00;
    d = 8'h00;
  end
  task automatic wr(input logic [7:0] ra, input logic [7:0] q [$],
    input int gap);
    @(posedge clk);
    av <= 1'b1;
    a <= ra;
    @(posedge clk);
    av <= 1'b0;
    // released lines show the inverse, never the last value
    a <= ~ra;
    foreach (q[i])
    begin
      dv <= 1'b1;
      d <= q[i];
      @(posedge clk);
      if (gap > 0 || i == q.size() - 1)
      begin
        dv <= 1'b0;
        d <= ~q[i];
        repeat (gap) @(posedge clk);
      end
    end
  endtask
endmodule // lpcb_host

// *** dv/testbench.sv ***
// self-checking bench of the led bank top with a host byte model
// assumes prescale 1, so one pwm period is 256 clocks
`timescale 1ns/1ps
module testbench
  import lpcb_pkg::*;
;
  logic MCLK, RST_B, HW_HALT_N_PIN, av, dv, SOFT_RUN, HALTED, run;
  logic [7:0] a, d;
  logic [17:0] CHANNEL_OUTPUT, he, ae;
  lpcb_byte_t hd [18];
  lpcb_byte_t ad [18];
  int errors, num_checks;
  lpcb_host host_u (.clk(MCLK), .av(av), .a(a), .dv(dv), .d(d));
  lpcb_top #(.NCH(18), .PWM_PRESCALE(1)) dut_u (.MCLK(MCLK), .RST_B(RST_B),
    .ADDR_BYTE_VALID(av), .ADDR_BYTE(a), .DATA_BYTE_VALID(dv),
    .DATA_BYTE(d), .HW_HALT_N_PIN(HW_HALT_N_PIN),
    .CHANNEL_OUTPUT(CHANNEL_OUTPUT), .SOFT_RUN(SOFT_RUN), .HALTED(HALTED));
  task automatic chk(input bit ok, input string m);
    num_checks++;
    if (!ok)
    begin
      errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic conclude();
    if (errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // expected register set back at its defaults
  task automatic clear_model();
    run = 1'b0;
    he = '0;
    ae = '0;
    foreach (hd[k])
    begin
      hd[k] = 8'h00;
      ad[k] = 8'h00;
    end
  endtask
  // model follows each byte at the stepping pointer
  task automatic put(input lpcb_byte_t ra, input lpcb_byte_t q [$]);
    int p;
    p = ra;
    host_u.wr(ra, q, $urandom_range(0, 2));
    foreach (q[i])
    begin
      if (p == 0) run = q[i][0];
      else if (p <= 18) hd[p-1] = q[i];
      else if (p <= 21) he[(p-19)*6 +: 6] = q[i][5:0];
      else if (p == 22)
      begin
        ad = hd;
        ae = he;
      end
      else if (p == 23) clear_model();
      p = (p + 1) % 256;
    end
  endtask
  function automatic int expd(int k);
    return (run && HW_HALT_N_PIN && ae[k]) ? int'(ad[k]) : 0;
  endfunction
  task automatic meas();
    int c [18];
    repeat (6) @(negedge MCLK);
    repeat (256)
    begin
      @(negedge MCLK);
      foreach (c[k]) c[k] += int'(CHANNEL_OUTPUT[k] === 1'b1);
    end
    foreach (c[k]) chk(c[k] == expd(k), "duty count");
  endtask
  initial
  begin
    MCLK = 1'b0;
    forever #12.5 MCLK = ~MCLK;
  end
  initial
  begin
    repeat (60000) @(posedge MCLK);
    chk(0, "timeout");
    conclude();
  end
  initial
  begin
    lpcb_byte_t q [$];
    RST_B = 1'b0;
    HW_HALT_N_PIN = 1'b1;
    clear_model();
    void'($urandom(32'hd5e4b08b));
    repeat (4) @(posedge MCLK);
    RST_B <= 1'b1;
    repeat (4) @(negedge MCLK);
    chk(CHANNEL_OUTPUT === 18'h0 && HALTED === 1'b1, "dark");
    chk(SOFT_RUN === 1'b0, "run default");
    for (int r = 0; r < 2; r++)
    begin
      q = '{8'h01};
      for (int k = 0; k < 18; k++)
        q.push_back(k < 3 ? 8'(8'h04 + 8'hfc * k) : 8'($urandom));
      repeat (3) q.push_back(r ? 8'hff : 8'($urandom));
      put(8'h00, q);
      meas();
      put(8'h16, '{8'($urandom)});
      meas();
    end
    put(8'h00, '{8'hfe});
    @(negedge MCLK);
    chk(SOFT_RUN === 1'b0, "run clear");
    meas();
    put(8'h00, '{8'h01});
    meas();
    @(posedge MCLK);
    HW_HALT_N_PIN <= 1'b0;
    meas();
    chk(HALTED === 1'b1, "pin halt");
    @(posedge MCLK);
    HW_HALT_N_PIN <= 1'b1;
    meas();
    put(8'h17, '{8'($urandom), 8'h01});
    @(negedge MCLK);
    chk(SOFT_RUN === 1'b0, "soft reset");
    put(8'h00, '{8'h01});
    put(8'h16, '{8'h5a});
    meas();
    // breathing steps taken from the two gamma curves
    put(8'h01, '{8'h0d});
    put(8'h02, '{8'hed});
    put(8'h13, '{8'h03});
    put(8'h16, '{8'h00});
    meas();
    conclude();
  end
endmodule // testbench
bind lpcb_top lpcb_chk #(.NCH(NCH)) chk_u (.MCLK(MCLK), .RST_B(RST_B),
  .ADDR_BYTE_VALID(ADDR_BYTE_VALID), .ADDR_BYTE(ADDR_BYTE),
  .DATA_BYTE_VALID(DATA_BYTE_VALID), .DATA_BYTE(DATA_BYTE),
  .HW_HALT_N_PIN(HW_HALT_N_PIN), .CHANNEL_OUTPUT(CHANNEL_OUTPUT),
  .SOFT_RUN(SOFT_RUN), .HALTED(HALTED));
